// ===== common/dpsd_defines.vh
// Field positions, codes and counts for the serial divider block
`ifndef DPSD_DEFINES_VH
`define DPSD_DEFINES_VH
`define DPSD_SR_W 23
`define DPSD_DEST_IF_REF 2'h0
`define DPSD_DEST_RF_REF 2'h1
`define DPSD_DEST_IF_PRG 2'h2
`define DPSD_DEST_RF_PRG 2'h3
`define DPSD_REF_LSB 4
`define DPSD_REF_W 14
`define DPSD_TEST_LSB 2
`define DPSD_LDS_BIT 2
`define DPSD_MOD_BIT 3
`define DPSD_PHP_BIT 4
`define DPSD_SWC_LSB 5
`define DPSD_SWC_W 7
`define DPSD_PRG_LSB 12
`define DPSD_PRG_W 11
`define DPSD_MIN_RATIO 5
`define DPSD_IF_P_LO 8'h10
`define DPSD_IF_P_HI 8'h20
`define DPSD_RF_P_LO 8'h40
`define DPSD_RF_P_HI 8'h80
`define DPSD_REG_OFF_CTRL 32'h0000_0000
`define DPSD_REG_OFF_IF_REF 32'h0000_0004
`define DPSD_REG_OFF_IF_PRG 32'h0000_0008
`define DPSD_REG_OFF_RF_REF 32'h0000_000C
`define DPSD_REG_OFF_RF_PRG 32'h0000_0010
`define DPSD_REG_OFF_STATUS 32'h0000_0014
`define DPSD_REG_OFF_TOTAL 32'h0000_0018
`endif

// ===== rtl/dpsd_sync.v
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module dpsd_sync #(
  parameter W = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] stab_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {W{1'b0}};
      stab_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      stab_q <= meta_q;
    end
  end
  assign sync_out = stab_q;
endmodule // dpsd_sync
`default_nettype wire

// ===== rtl/dpsd_div.v
// Programmable divider producing one-cycle enable pulses
`timescale 1ns/1ns
`default_nettype none
module dpsd_div #(
  parameter W = 14
) (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire step,
  input wire [W-1:0] ratio,
  output reg tick
);
  reg [W-1:0] cnt_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b0;
    end else if (!run) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b0;
    end else if (!step) begin
      tick <= 1'b0;
    end else if (cnt_q + {{(W-1){1'b0}}, 1'b1} >= ratio) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule // dpsd_div
`default_nettype wire

// ===== rtl/dpsd_top.v
// Serial programming, latches, dividers and APB view of the synthesizer
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "dpsd_defines.vh"
// Contract
// R01: Each serial clock rising edge shifts one data bit into 23-bit register.
// R02: Load strobe high copies shift register into the selected latch.
// R03: Four latches: IF ref, IF program, RF ref, RF program.
// R04: Select bits low-low IF ref, high-low RF ref, low-high IF, high-high RF prog.
// R05: Reference divider is 14 bits, ratios 5 to 16383.
// R06: Program divider is 11 bits, ratios 5 to 2047.
// R07: Swallow counter 7 bits 0 to 127, host keeps it below program count.
// R08: Prescaler 16/32 IF, 64/128 RF; total is base times N plus A.
// R09: Lock pin shows monitor when select bit high, lock indicator when low.
// R10: Each section runs while its sleep pin high, sleeps while low.
// R11: Host holds both sleep pins low at power-on, never floating.
// R12: Phase polarity bit inverts the section's charge pump polarity.
// R13: Losing RF supply clears all latched RF configuration.
// R14: Each latch loads by its own transfer without touching the others. Code keeps one lds_q that both program loads write.
// R15: Sleeping section drives its charge pump output high impedance.
// R16: Latches count as undefined until all four have been written.
// R17: Modulus select bit chooses lower or higher prescaler base ratio.
module dpsd_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ser_data,
  input wire ser_clk,
  input wire load_strobe,
  input wire if_sleep_n,
  input wire rf_sleep_n,
  input wire rf_supply,
  input wire ref_osc_in,
  input wire if_fb_in,
  input wire rf_fb_in,
  output reg lock_monitor_pin,
  output reg if_pump_up,
  output reg if_pump_dn,
  output reg if_pump_oe,
  output reg rf_pump_up,
  output reg rf_pump_dn,
  output reg rf_pump_oe,
  output reg config_valid
);
  localparam SR_W = `DPSD_SR_W;

  // Pin inputs into the pclk domain
  wire [8:0] pin_s;
  dpsd_sync #(.W(9)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({rf_fb_in, if_fb_in, ref_osc_in, rf_supply, rf_sleep_n,
      if_sleep_n, load_strobe, ser_clk, ser_data}),
    .sync_out(pin_s)
  );
  wire data_s = pin_s[0];
  wire sclk_s = pin_s[1];
  wire le_s = pin_s[2];
  wire if_on = pin_s[3];
  wire rf_on_pin = pin_s[4];
  wire rf_pwr = pin_s[5];
  wire osc_s = pin_s[6];
  wire iffb_s = pin_s[7];
  wire rffb_s = pin_s[8];
  // RF section needs both its sleep pin and its supply
  wire rf_on = rf_on_pin & rf_pwr;

  // Edge history resets low, the idle level of the pins
  reg sclk_q, osc_q, iffb_q, rffb_q, rfpwr_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
      osc_q <= 1'b0;
      iffb_q <= 1'b0;
      rffb_q <= 1'b0;
      rfpwr_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
      osc_q <= osc_s;
      iffb_q <= iffb_s;
      rffb_q <= rffb_s;
      rfpwr_q <= rf_pwr;
    end
  end
  wire sclk_rise = sclk_s & ~sclk_q;
  wire osc_rise = osc_s & ~osc_q;
  wire rf_pwr_fall = rfpwr_q & ~rf_pwr;

  // R01: serial shift in
  reg [SR_W-1:0] sr_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sr_q <= {SR_W{1'b0}};
    else if (sclk_rise)
      sr_q <= {sr_q[SR_W-2:0], data_s};
  end

  // Last bit sent is bit 0 of the map and lands in sr_q[0],
  // so the register already holds the word in map order
  wire [SR_W-1:0] w = sr_q;
  // R04: destination decode
  wire [1:0] dest = {w[1], w[0]};

  reg [13:0] if_ref_q, rf_ref_q;
  reg [1:0] if_test_q, rf_test_q;
  reg [10:0] if_n_q, rf_n_q;
  reg [6:0] if_a_q, rf_a_q;
  reg if_mod_q, rf_mod_q, if_php_q, rf_php_q, lds_q;
  reg [3:0] written_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      if_ref_q <= 14'h0005;
      rf_ref_q <= 14'h0005;
      if_test_q <= 2'h0;
      rf_test_q <= 2'h0;
      if_n_q <= 11'h005;
      rf_n_q <= 11'h005;
      if_a_q <= 7'h00;
      rf_a_q <= 7'h00;
      if_mod_q <= 1'b0;
      rf_mod_q <= 1'b0;
      if_php_q <= 1'b0;
      rf_php_q <= 1'b0;
      lds_q <= 1'b0;
      written_q <= 4'h0;
    end else begin
      // R13: RF latches lost with supply
      // IF loads still go ahead in the cycle the supply drops
      if (rf_pwr_fall) begin
        rf_ref_q <= 14'h0005;
        rf_test_q <= 2'h0;
        rf_n_q <= 11'h005;
        rf_a_q <= 7'h00;
        rf_mod_q <= 1'b0;
        rf_php_q <= 1'b0;
        written_q[1] <= 1'b0;
        written_q[3] <= 1'b0;
      end
      // R02: transfer while strobe high
      if (le_s) begin
        // R03: only the selected latch
        // R14: others untouched, except lds_q, shared by both program latches
        case (dest)
          `DPSD_DEST_IF_REF: begin
            // R05: 14-bit reference ratio
            if_ref_q <= w[`DPSD_REF_LSB +: `DPSD_REF_W];
            if_test_q <= w[`DPSD_TEST_LSB +: 2];
            written_q[0] <= 1'b1;
          end
          `DPSD_DEST_RF_REF: if (rf_pwr) begin
            rf_ref_q <= w[`DPSD_REF_LSB +: `DPSD_REF_W];
            rf_test_q <= w[`DPSD_TEST_LSB +: 2];
            written_q[1] <= 1'b1;
          end
          `DPSD_DEST_IF_PRG: begin
            // R06: 11-bit program count
            // R07: 7-bit swallow count
            if_n_q <= w[`DPSD_PRG_LSB +: `DPSD_PRG_W];
            if_a_q <= w[`DPSD_SWC_LSB +: `DPSD_SWC_W];
            if_mod_q <= w[`DPSD_MOD_BIT];
            if_php_q <= w[`DPSD_PHP_BIT];
            lds_q <= w[`DPSD_LDS_BIT];
            written_q[2] <= 1'b1;
          end
          default: if (rf_pwr) begin
            rf_n_q <= w[`DPSD_PRG_LSB +: `DPSD_PRG_W];
            rf_a_q <= w[`DPSD_SWC_LSB +: `DPSD_SWC_W];
            rf_mod_q <= w[`DPSD_MOD_BIT];
            rf_php_q <= w[`DPSD_PHP_BIT];
            lds_q <= w[`DPSD_LDS_BIT];
            written_q[3] <= 1'b1;
          end
        endcase
      end
    end
  end

  // R17: modulus bit high selects lower base
  // R08: base ratio per section
  wire [7:0] if_p = if_mod_q ? `DPSD_IF_P_LO : `DPSD_IF_P_HI;
  wire [7:0] rf_p = rf_mod_q ? `DPSD_RF_P_LO : `DPSD_RF_P_HI;
  // R08: total feedback division P*N+A
  wire [18:0] if_total = if_p * if_n_q + {12'h000, if_a_q};
  wire [18:0] rf_total = rf_p * rf_n_q + {12'h000, rf_a_q};

  // Reference dividers, one tick per ratio oscillator edges
  wire if_fr_q;
  wire rf_fr_q;
  // R10: counting only while awake
  dpsd_div #(.W(`DPSD_REF_W)) u_if_rdiv (
    .pclk(pclk),
    .presetn(presetn),
    .run(if_on),
    .step(osc_rise),
    .ratio(if_ref_q),
    .tick(if_fr_q)
  );
  // RF divider also stops without its supply
  dpsd_div #(.W(`DPSD_REF_W)) u_rf_rdiv (
    .pclk(pclk),
    .presetn(presetn),
    .run(rf_on),
    .step(osc_rise),
    .ratio(rf_ref_q),
    .tick(rf_fr_q)
  );

  // Feedback dividers count fed-back edges up to P*N+A
  reg [18:0] if_fc_q, rf_fc_q;
  reg if_fp_q, rf_fp_q;
  wire if_fb_rise = iffb_s & ~iffb_q;
  wire rf_fb_rise = rffb_s & ~rffb_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      if_fc_q <= 19'h0_0000;
      rf_fc_q <= 19'h0_0000;
      if_fp_q <= 1'b0;
      rf_fp_q <= 1'b0;
    end else begin
      if_fp_q <= 1'b0;
      rf_fp_q <= 1'b0;
      if (!if_on)
        if_fc_q <= 19'h0_0000;
      else if (if_fb_rise) begin
        if (if_fc_q + 19'h0_0001 >= if_total) begin
          if_fc_q <= 19'h0_0000;
          if_fp_q <= 1'b1;
        end else
          if_fc_q <= if_fc_q + 19'h0_0001;
      end
      if (!rf_on)
        rf_fc_q <= 19'h0_0000;
      else if (rf_fb_rise) begin
        if (rf_fc_q + 19'h0_0001 >= rf_total) begin
          rf_fc_q <= 19'h0_0000;
          rf_fp_q <= 1'b1;
        end else
          rf_fc_q <= rf_fc_q + 19'h0_0001;
      end
    end
  end

  // Phase detector: reference leads sets pd bit 1 (up only with the polarity bit high), feedback leads sets pd bit 0
  reg [1:0] if_pd_q, rf_pd_q;
  reg lock_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      if_pd_q <= 2'b00;
      rf_pd_q <= 2'b00;
      lock_q <= 1'b0;
    end else begin
      if (if_fr_q && !if_fp_q)
        if_pd_q <= 2'b10;
      else if (if_fp_q && !if_fr_q)
        if_pd_q <= 2'b01;
      else if (if_fr_q && if_fp_q)
        if_pd_q <= 2'b00;
      if (rf_fr_q && !rf_fp_q)
        rf_pd_q <= 2'b10;
      else if (rf_fp_q && !rf_fr_q)
        rf_pd_q <= 2'b01;
      else if (rf_fr_q && rf_fp_q)
        rf_pd_q <= 2'b00;
      lock_q <= (if_pd_q == 2'b00 || !if_on) && (rf_pd_q == 2'b00 || !rf_on);
    end
  end

  // Pump pins and lock monitor
  reg mon_sel;
  always @* begin
    case ({if_test_q[0], if_test_q[1]})
      2'b00: mon_sel = if_fr_q;
      2'b10: mon_sel = rf_fr_q;
      2'b01: mon_sel = if_fp_q;
      default: mon_sel = rf_fp_q;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      if_pump_up <= 1'b0;
      if_pump_dn <= 1'b0;
      if_pump_oe <= 1'b0;
      rf_pump_up <= 1'b0;
      rf_pump_dn <= 1'b0;
      rf_pump_oe <= 1'b0;
      lock_monitor_pin <= 1'b0;
      config_valid <= 1'b0;
    end else begin
      // R12: polarity swaps up and down
      if_pump_up <= if_php_q ? if_pd_q[1] : if_pd_q[0];
      if_pump_dn <= if_php_q ? if_pd_q[0] : if_pd_q[1];
      rf_pump_up <= rf_php_q ? rf_pd_q[1] : rf_pd_q[0];
      rf_pump_dn <= rf_php_q ? rf_pd_q[0] : rf_pd_q[1];
      // R15: sleeping pump floats
      if_pump_oe <= if_on && (if_pd_q != 2'b00);
      rf_pump_oe <= rf_on && (rf_pd_q != 2'b00);
      // R09: monitor or lock indicator
      lock_monitor_pin <= lds_q ? mon_sel : lock_q;
      // R16: valid after all four loads
      config_valid <= &written_q;
    end
  end

  // APB slave, zero wait states
  // Read data launched at setup stands in the access cycle
  wire apb_acc = psel & penable;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `DPSD_REG_OFF_CTRL:
            prdata <= {27'h000_0000, lds_q, rf_php_q, if_php_q, rf_mod_q,
              if_mod_q};
          `DPSD_REG_OFF_IF_REF: prdata <= {16'h0000, if_test_q, if_ref_q};
          `DPSD_REG_OFF_IF_PRG: prdata <= {14'h0000, if_n_q, if_a_q};
          `DPSD_REG_OFF_RF_REF: prdata <= {16'h0000, rf_test_q, rf_ref_q};
          `DPSD_REG_OFF_RF_PRG: prdata <= {14'h0000, rf_n_q, rf_a_q};
          `DPSD_REG_OFF_STATUS:
            prdata <= {24'h00_0000, lock_q, rf_on, if_on, rf_pwr, written_q};
          `DPSD_REG_OFF_TOTAL: prdata <= {if_total[15:0], rf_total[15:0]};
          default: pslverr <= 1'b1;
        endcase
        if (pwrite)
          pslverr <= 1'b1;
      end
    end
  end
  wire unused_ok = apb_acc | (|pwdata);
endmodule // dpsd_top
`default_nettype wire

// ===== sim/dpsd_props.sv
// Port assertions for the serial divider block
`timescale 1ns/1ns
`default_nettype none
module dpsd_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic load_strobe,
  input wire logic if_sleep_n,
  input wire logic rf_sleep_n,
  input wire logic rf_supply,
  input wire logic if_pump_oe,
  input wire logic rf_pump_oe,
  input wire logic config_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] since_q;
  logic [3:0] since_d;
  // Cycles since the strobe was last high
  always_comb since_d = load_strobe ? 4'h0 :
    (since_q == 4'hf ? since_q : since_q + 4'h1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) since_q <= 4'hf;
    else since_q <= since_d;
  end
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_write: assert property (psel && !penable && pwrite |=> pslverr)
    else $error("write not refused");
  a_if_sleep_hiz: assert property (!if_sleep_n [*5] |-> !if_pump_oe)
    else $error("IF pump driven while asleep");
  a_rf_sleep_hiz: assert property (!rf_sleep_n [*5] |-> !rf_pump_oe)
    else $error("RF pump driven while asleep");
  a_rf_supply_loss: assert property (!rf_supply [*6] |-> !config_valid)
    else $error("RF latches kept without supply");
  a_valid_cause: assert property ($rose(config_valid) |-> since_q < 4'h9)
    else $error("latches marked written without a strobe");
  a_reset_quiet: assert property ($rose(presetn) |-> !pready && !config_valid)
    else $error("outputs active at reset release");
endmodule // dpsd_props
bind dpsd_top dpsd_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .load_strobe(load_strobe), .if_sleep_n(if_sleep_n),
  .rf_sleep_n(rf_sleep_n), .rf_supply(rf_supply),
  .if_pump_oe(if_pump_oe), .rf_pump_oe(rf_pump_oe),
  .config_valid(config_valid));
`default_nettype wire

// ===== sim/dpsd_host.sv
// Host model driving the serial and sleep pins
`timescale 1ns/1ns
`default_nettype none
module dpsd_host (
  input wire logic pclk,
  output logic ser_data,
  output logic ser_clk,
  output logic load_strobe,
  output logic if_sleep_n,
  output logic rf_sleep_n
);
  initial begin
    if_sleep_n = 1'b0;
    rf_sleep_n = 1'b0;
    ser_data = 1'b0;
    ser_clk = 1'b0;
    load_strobe = 1'b0;
  end
  task automatic sleep(input logic [1:0] v);
    if_sleep_n <= v[0];
    rf_sleep_n <= v[1];
  endtask
  // MSB first, one bit per rising clock
  task automatic send(input logic [22:0] w);
    @(posedge pclk);
    for (int i = 22; i >= 0; i--) begin
      ser_data <= w[i];
      repeat (6) @(posedge pclk);
      ser_clk <= 1'b1;
      repeat (6) @(posedge pclk);
      ser_clk <= 1'b0;
    end
    // Released data line shows the inverse
    ser_data <= ~w[0];
    repeat (6) @(posedge pclk);
    // strobe only with the clock idle
    load_strobe <= 1'b1;
    repeat (8) @(posedge pclk);
    load_strobe <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule // dpsd_host
`default_nettype wire

// ===== sim/dpsd_top_tb_top.sv
// Self-checking bench for the serial divider block
`timescale 1ns/1ns
`default_nettype none
module dpsd_top_tb_top;
  typedef struct {logic s; logic [22:0] w; logic [31:0] a, m, e;} dpsd_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rf_supply;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic ser_data, ser_clk, load_strobe, if_sleep_n, rf_sleep_n, er;
  logic ref_osc_in, if_fb_in, rf_fb_in, lock_monitor_pin, config_valid;
  logic if_pump_up, if_pump_dn, if_pump_oe, rf_pump_up, rf_pump_dn, rf_pump_oe;
  int bad_count = 0;
  int compares = 0;
  dpsd_row_t rows [8];
  dpsd_top DUT (.*);
  dpsd_host u_host (.*);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) ref_osc_in <= ~ref_osc_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'hffff_ffff;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait on the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // destination code in the two low bits
  function automatic logic [22:0] refw(logic [1:0] d, logic [1:0] t,
      logic [13:0] r);
    return {5'h0, r, t, d};
  endfunction
  // callers keep the swallow count below the program count
  function automatic logic [22:0] prgw(logic [1:0] d, logic [10:0] n,
      logic [6:0] a, logic [2:0] f);
    return {n, a, f, d};
  endfunction
  initial begin
    {psel, penable, pwrite, presetn, ref_osc_in, if_fb_in, rf_fb_in} = '0;
    rf_supply = 1'b1;
    paddr = '0;
    pwdata = '0;
    rows[0] = '{1, refw(2'h0, 2'h3, 14'h1234), 32'h4, '1, 32'hd234};
    rows[1] = '{1, refw(2'h1, 2'h0, 14'h3fff), 32'hc, '1, 32'h3fff};
    rows[2] = '{1, prgw(2'h2, 11'h7ff, 7'h7f, 3'h7), 32'h8, '1, 32'h3_ffff};
    rows[3] = '{1, prgw(2'h3, 11'h005, 7'h00, 3'h4), 32'h10, '1, 32'h280};
    rows[4] = '{0, '0, 32'h0, '1, 32'hd};
    rows[5] = '{0, '0, 32'h14, 32'hf, 32'hf};
    rows[6] = '{0, '0, 32'h18, '1, 32'h806f_0280};
    rows[7] = '{0, '0, 32'h4, '1, 32'hd234};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 32'h14);
    chk(rd & 32'hf, 32'h0);
    u_host.sleep(2'h3);
    foreach (rows[i]) begin
      if (rows[i].s) u_host.send(rows[i].w);
      apb(1'b0, rows[i].a);
      chk(rd & rows[i].m, rows[i].e);
    end
    chk(32'(config_valid), 32'h1);
    apb(1'b1, 32'h4);
    chk(32'(er), 32'h1);
    apb(1'b0, 32'h40);
    chk(32'(er), 32'h1);
    chk({if_pump_up, if_pump_dn, if_pump_oe, rf_pump_up, rf_pump_dn, rf_pump_oe,
      lock_monitor_pin}, 32'h5a);
    rf_supply <= 1'b0;
    repeat (8) @(posedge pclk);
    u_host.send(refw(2'h1, 2'h0, 14'h0100));
    apb(1'b0, 32'h14);
    chk(rd & 32'hf, 32'h5);
    chk(32'(config_valid), 32'h0);
    u_host.sleep(2'h0);
    repeat (8) @(posedge pclk);
    chk({if_pump_oe, rf_pump_oe}, 32'h0);
    chk(32'(lock_monitor_pin), 32'h1);
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end
endmodule // dpsd_top_tb_top
`default_nettype wire
